// ===== inc/atc_pkg.sv
// shared constants, state type and bus-lane helpers for the terminal core
package atc_pkg;
  localparam int unsigned WORD_W = 32;
  localparam int unsigned HALF_W = 16;
  localparam int unsigned FIFO_DEPTH = 32;
  localparam int unsigned LABEL_N = 16;
  localparam int unsigned LABEL_W = 8;
  localparam int unsigned PAR_BIT = 31;
  localparam int unsigned DEC_LSB = 8;
  localparam int unsigned LAST_BIT = 31;
  // register byte addresses
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_STATUS = 8'h04;
  localparam logic [7:0] A_TX_LO = 8'h08;
  localparam logic [7:0] A_TX_HI = 8'h0C;
  localparam logic [7:0] A_RX1_LO = 8'h10;
  localparam logic [7:0] A_MODE = 8'h20;
  localparam logic [7:0] CH_STRIDE = 8'h08;
  localparam logic [7:0] HALF_STEP = 8'h04;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam logic [15:0] CTRL_RST = 16'h0020;
  // control bit positions
  localparam int unsigned CB_LBL = 1;
  localparam int unsigned CB_M1 = 2;
  localparam int unsigned CB_PAR = 4;
  localparam int unsigned CB_LOOP_N = 5;
  localparam int unsigned CB_D1 = 6;
  localparam int unsigned CB_DSTEP = 3;
  localparam int unsigned CB_SENSE = 12;
  localparam int unsigned CB_RATE = 13;
  localparam int unsigned CB_ORDER = 15;
  localparam int unsigned SB_N = 9;
  // pin order: test, tx enable, master reset
  localparam logic [2:0] PIN_RST = 3'h1;
  // master clock derived from the 10 MHz reference
  localparam int unsigned MCLK_PERIOD_NS = 1000;
  localparam int unsigned REF_PERIOD_NS = 100;
  localparam int unsigned MCLK_DIV = MCLK_PERIOD_NS / REF_PERIOD_NS;
  localparam int unsigned DIV_W = 4;
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(MCLK_DIV - 1);
  // line timing in master clocks
  localparam int unsigned HS_HALF_CLK = 5;
  localparam int unsigned HS_GAP_CLK = 40;
  localparam int unsigned LS_HALF_CLK = 40;
  localparam int unsigned LS_GAP_CLK = 320;
  localparam logic [8:0] HS_HALF_LD = 9'(HS_HALF_CLK - 1);
  localparam logic [8:0] LS_HALF_LD = 9'(LS_HALF_CLK - 1);
  // gap state is followed by one idle tick before the next word
  localparam logic [8:0] HS_GAP_LD = 9'(HS_GAP_CLK - 2);
  localparam logic [8:0] LS_GAP_LD = 9'(LS_GAP_CLK - 2);
  typedef enum logic [1:0] {
    TX_IDLE = 2'h0, TX_DATA = 2'h1, TX_NULL = 2'h3, TX_GAP = 2'h2
  } atc_tx_state_t;
  function automatic logic [HALF_W-1:0] to_bus(input logic [WORD_W-1:0] w,
                                                input logic order, input logic hi);
    if (order) return hi ? w[31:16] : w[15:0];
    return hi ? w[28:13] : {w[12:8], w[30:29], w[31], w[7:0]};
  endfunction
  function automatic logic [WORD_W-1:0] from_bus(input logic [HALF_W-1:0] lo,
                                                  input logic [HALF_W-1:0] hi, input logic order);
    if (order) return {hi, lo};
    return {lo[8], lo[10:9], hi, lo[15:11], lo[7:0]};
  endfunction
endpackage

// ===== inc/atc_rx_if.sv
// link between the core and one receive channel
interface atc_rx_if;
  logic clear;
  logic suspend;
  logic match_on;
  logic dec_on;
  logic [1:0] dec_bits;
  logic in_valid;
  logic [atc_pkg::WORD_W-1:0] in_word;
  logic pop;
  logic lbl_restart;
  logic lbl_wr;
  logic lbl_rd;
  logic [atc_pkg::LABEL_W-1:0] lbl_data;
  logic [atc_pkg::WORD_W-1:0] head;
  logic [atc_pkg::LABEL_W-1:0] lbl_out;
  logic rdy;
  logic half;
  logic full;
  logic accepted;
  modport core (
    output clear, suspend, match_on, dec_on, dec_bits, in_valid, in_word, pop,
    output lbl_restart, lbl_wr, lbl_rd, lbl_data,
    input head, lbl_out, rdy, half, full, accepted
  );
  modport chan (
    input clear, suspend, match_on, dec_on, dec_bits, in_valid, in_word, pop,
    input lbl_restart, lbl_wr, lbl_rd, lbl_data,
    output head, lbl_out, rdy, half, full, accepted
  );
endinterface

// ===== logic/atc_rx_chan.sv
// one receive channel: label memory, word filter and word fifo
module atc_rx_chan #(
  parameter int unsigned DEPTH = atc_pkg::FIFO_DEPTH,
  parameter int unsigned LABELS = atc_pkg::LABEL_N
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // core side
  atc_rx_if.chan bus
);
  localparam int unsigned PW = $clog2(DEPTH);
  localparam int unsigned CW = $clog2(DEPTH + 1);
  localparam int unsigned LW = $clog2(LABELS + 1);
  logic [atc_pkg::WORD_W-1:0] mem [DEPTH];
  logic [PW-1:0] wp_q, rp_q, last;
  logic [CW-1:0] cnt_q;
  logic [atc_pkg::LABEL_W-1:0] lbl_q [LABELS];
  logic [LW-1:0] lwi_q, lri_q;
  logic [LABELS-1:0] hit;
  logic dec_ok, keep, over, lwr;

  for (genvar i = 0; i < LABELS; i++) begin : g_hit
    assign hit[i] = lbl_q[i] == bus.in_word[atc_pkg::LABEL_W-1:0];
  end
  assign dec_ok = bus.in_word[atc_pkg::DEC_LSB +: 2] == bus.dec_bits;
  assign keep = bus.in_valid && !bus.suspend && !bus.clear
      && (!bus.match_on || |hit) && (!bus.dec_on || dec_ok);
  assign bus.full = cnt_q == CW'(DEPTH);
  assign bus.half = cnt_q >= CW'(DEPTH / 2);
  assign bus.rdy = cnt_q != CW'(0);
  assign over = keep && bus.full && !bus.pop;
  assign last = wp_q - PW'(1);
  assign bus.head = mem[rp_q];
  assign bus.accepted = keep;

  // full fifo: newest word replaced in place
  always_ff @(posedge clk) begin
    if (keep) begin
      mem[over ? last : wp_q] <= {~^bus.in_word, bus.in_word[atc_pkg::PAR_BIT-1:0]};
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end else if (bus.clear) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end else begin
      if (keep && !over) wp_q <= wp_q + PW'(1);
      if (bus.pop) rp_q <= rp_q + PW'(1);
      cnt_q <= cnt_q + CW'(keep && !over) - CW'(bus.pop);
    end
  end

  assign lwr = bus.lbl_wr && (lwi_q < LW'(LABELS));
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lwi_q <= '0;
      lri_q <= '0;
    end else if (bus.lbl_restart) begin
      lwi_q <= '0;
      lri_q <= '0;
    end else begin
      if (lwr) lwi_q <= lwi_q + LW'(1);
      if (bus.lbl_rd && lri_q < LW'(LABELS)) lri_q <= lri_q + LW'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (lwr) lbl_q[lwi_q[LW-2:0]] <= bus.lbl_data;
  end
  assign bus.lbl_out = (lri_q < LW'(LABELS)) ? lbl_q[lri_q[LW-2:0]] : '0;
endmodule

// ===== logic/atc_core.sv
// terminal core top: ahb-lite registers, receive flags, transmit fifo and line timing

// Functional notes
// - ready low until fifo empty, halves read
// - word read as low then high half
// - receive fifo holds 32, full pin low
// - full fifo: new word overwrites last position
// - half pin low at sixteen or more
// - unmatched labels discarded, no ready raised
// - label zero normal; data bits 0-7 compared
// - label access rise: next sixteen writes load labels
// - reception suspended while labels are written
// - label access rise: next sixteen reads return labels
// - two half writes store one word
// - full transmit fifo ignores further loads
// - transmit half pin high below sixteen words
// - enable starts oldest word quickly on line
// - bit, null and gap lengths per rate
// - transmitter ready once all words sent
// - parity bit odd or even, or data
// - self test loops data; test forces null
// - rate select gives fast or slow rate
// - repeater copies read word into transmit fifo
// - master reset clears fifos, keeps control
// - label and decoder filter before fifo
// - stored bit 32 flags even parity
module atc_core #(
  parameter int unsigned TX_DEPTH = atc_pkg::FIFO_DEPTH
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // device pins
  input wire logic master_reset_n,
  input wire logic tx_enable,
  input wire logic test_mode,
  // words from the receive bit checkers
  input wire logic rx1_word_valid,
  input wire logic [31:0] rx1_word,
  input wire logic rx2_word_valid,
  input wire logic [31:0] rx2_word,
  // flag pins
  output logic rx1_ready_n,
  output logic rx2_ready_n,
  output logic rx1_half_n,
  output logic rx2_half_n,
  output logic rx1_full_n,
  output logic rx2_full_n,
  output logic tx_full_n,
  output logic tx_half_n,
  output logic tx_ready,
  output logic word_complete_pulse,
  // line driver and loopback
  output logic line_out_a,
  output logic line_out_b,
  output logic line_slope_slow,
  output logic loop_rx1_a,
  output logic loop_rx1_b,
  output logic loop_rx2_a,
  output logic loop_rx2_b
);
  localparam int unsigned PW = $clog2(TX_DEPTH);
  localparam int unsigned CW = $clog2(TX_DEPTH + 1);
  localparam int unsigned PIN_N = 3;

  logic [1:0] rst_sync_q;
  logic rst_n;
  logic [PIN_N-1:0] pin_raw, pin_q;
  logic mr, ten, tst;
  logic [atc_pkg::DIV_W-1:0] div_q;
  logic mtick;
  logic [15:0] ctrl_q;
  logic repeat_q;
  logic ap, rd, wr, wr_pend_q;
  logic [7:0] a_now, addr_q;
  logic [31:0] rdata_d;
  logic [atc_pkg::SB_N-1:0] status;
  logic lbl_mode, lbl_rise;
  logic [15:0] tx_lo_q, push_hi;
  logic [31:0] push_word;
  logic cpu_lo_wr, cpu_push, rep_lo, rep_push, push, tx_go, tx_full;
  logic [31:0] tx_mem [TX_DEPTH];
  logic [PW-1:0] tx_wp_q, tx_rp_q;
  logic [CW-1:0] tx_cnt_q;
  atc_pkg::atc_tx_state_t st_q;
  logic [8:0] tcnt_q, half_ld, gap_ld;
  logic [4:0] bit_q;
  logic [31:0] sh_q;
  logic drv_a, drv_b, loop_on;

  // reset release
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'h1};
    end
  end
  assign rst_n = rst_sync_q[1];

  // pins: a level counts once the 2nd and 3rd stages agree
  assign pin_raw = {test_mode, tx_enable, master_reset_n};
  for (genvar p = 0; p < PIN_N; p++) begin : g_pin
    logic [2:0] s_q;
    logic f_q;
    always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
        s_q <= atc_pkg::PIN_RST[p] ? 3'h7 : 3'h0;
        f_q <= atc_pkg::PIN_RST[p];
      end else begin
        s_q <= {s_q[1:0], pin_raw[p]};
        if (s_q[1] == s_q[2]) f_q <= s_q[2];
      end
    end
    assign pin_q[p] = f_q;
  end
  assign mr = !pin_q[0];
  assign ten = pin_q[1];
  assign tst = pin_q[2];

  // 1 MHz master clock enable
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      div_q <= '0;
    end else if (mtick) begin
      div_q <= '0;
    end else begin
      div_q <= div_q + atc_pkg::DIV_W'(1);
    end
  end
  assign mtick = div_q == atc_pkg::DIV_LAST;

  // bus slave: zero wait, reads answered from the address phase
  assign ap = hsel && htrans[1] && hready && (hsize == atc_pkg::HSIZE_WORD);
  assign a_now = {haddr[7:2], 2'h0};
  assign rd = ap && !hwrite;
  assign wr = wr_pend_q;
  assign hreadyout = 1'h1;
  assign hresp = 1'h0;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_pend_q <= 1'h0;
      addr_q <= 8'h00;
    end else begin
      wr_pend_q <= ap && hwrite;
      if (ap) addr_q <= a_now;
    end
  end

  // control survives master reset
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= atc_pkg::CTRL_RST;
      repeat_q <= 1'h0;
    end else if (wr) begin
      if (addr_q == atc_pkg::A_CTRL) ctrl_q <= hwdata[15:0];
      if (addr_q == atc_pkg::A_MODE) repeat_q <= hwdata[0];
    end
  end
  assign lbl_mode = ctrl_q[atc_pkg::CB_LBL];
  assign lbl_rise = wr && addr_q == atc_pkg::A_CTRL && hwdata[atc_pkg::CB_LBL] && !lbl_mode;

  // receive channels
  atc_rx_if rx_if [2] ();
  for (genvar g = 0; g < 2; g++) begin : g_ch
    localparam logic [7:0] LO_A = 8'(atc_pkg::A_RX1_LO + g * atc_pkg::CH_STRIDE);
    localparam logic [7:0] HI_A = 8'(LO_A + atc_pkg::HALF_STEP);
    localparam int unsigned DB = atc_pkg::CB_D1 + g * atc_pkg::CB_DSTEP;
    logic sel_lo, sel_hi, take_lo, take_hi, got_lo_q, got_hi_q;
    logic [15:0] lo_v, hi_v, rdat;
    assign sel_lo = rd && a_now == LO_A;
    assign sel_hi = rd && a_now == HI_A;
    assign take_lo = sel_lo && rx_if[g].rdy;
    // high-half reads fetch labels in access mode
    assign take_hi = sel_hi && rx_if[g].rdy && !lbl_mode;
    assign lo_v = atc_pkg::to_bus(rx_if[g].head, ctrl_q[atc_pkg::CB_ORDER], 1'h0);
    assign hi_v = atc_pkg::to_bus(rx_if[g].head, ctrl_q[atc_pkg::CB_ORDER], 1'h1);
    always_comb begin
      rdat = 16'h0000;
      if (sel_hi && lbl_mode) begin
        rdat = {8'h00, rx_if[g].lbl_out};
      end else if (take_lo) begin
        rdat = lo_v;
      end else if (take_hi) begin
        rdat = hi_v;
      end
    end
    // word leaves the fifo only after both halves
    assign rx_if[g].pop = (take_lo && got_hi_q) || (take_hi && got_lo_q);
    always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
        got_lo_q <= 1'h0;
        got_hi_q <= 1'h0;
      end else if (mr || rx_if[g].pop) begin
        got_lo_q <= 1'h0;
        got_hi_q <= 1'h0;
      end else begin
        if (take_lo) got_lo_q <= 1'h1;
        if (take_hi) got_hi_q <= 1'h1;
      end
    end
    assign rx_if[g].clear = mr;
    assign rx_if[g].suspend = lbl_mode;
    assign rx_if[g].match_on = ctrl_q[atc_pkg::CB_M1 + g];
    assign rx_if[g].dec_on = ctrl_q[DB];
    assign rx_if[g].dec_bits = ctrl_q[DB + 1 +: 2];
    assign rx_if[g].in_valid = (g == 0) ? rx1_word_valid : rx2_word_valid;
    assign rx_if[g].in_word = (g == 0) ? rx1_word : rx2_word;
    assign rx_if[g].lbl_restart = lbl_rise;
    assign rx_if[g].lbl_rd = sel_hi && lbl_mode;
    // first-half writes feed channel 1, second-half writes channel 2
    assign rx_if[g].lbl_wr = wr && lbl_mode
        && addr_q == ((g == 0) ? atc_pkg::A_TX_LO : atc_pkg::A_TX_HI);
    assign rx_if[g].lbl_data = hwdata[atc_pkg::LABEL_W-1:0];
    atc_rx_chan u_chan (
      .clk(ref_clk),
      .rst_n(rst_n),
      .bus(rx_if[g])
    );
  end

  assign rx1_ready_n = !rx_if[0].rdy;
  assign rx2_ready_n = !rx_if[1].rdy;
  assign rx1_half_n = !rx_if[0].half;
  assign rx2_half_n = !rx_if[1].half;
  assign rx1_full_n = !rx_if[0].full;
  assign rx2_full_n = !rx_if[1].full;

  // transmit loading: cpu halves or repeater copy
  assign cpu_lo_wr = wr && addr_q == atc_pkg::A_TX_LO && !lbl_mode;
  assign cpu_push = wr && addr_q == atc_pkg::A_TX_HI && !lbl_mode;
  assign rep_lo = repeat_q && (g_ch[0].take_lo || g_ch[1].take_lo);
  assign rep_push = repeat_q && (g_ch[0].take_hi || g_ch[1].take_hi);
  assign push_hi = cpu_push ? hwdata[15:0] : (g_ch[0].take_hi ? g_ch[0].hi_v : g_ch[1].hi_v);
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_lo_q <= 16'h0000;
    end else if (cpu_lo_wr) begin
      tx_lo_q <= hwdata[15:0];
    end else if (rep_lo) begin
      tx_lo_q <= g_ch[0].take_lo ? g_ch[0].lo_v : g_ch[1].lo_v;
    end
  end
  always_comb begin
    push_word = atc_pkg::from_bus(tx_lo_q, push_hi, ctrl_q[atc_pkg::CB_ORDER]);
    if (ctrl_q[atc_pkg::CB_PAR]) begin
      push_word[atc_pkg::PAR_BIT] = ctrl_q[atc_pkg::CB_SENSE]
          ? ^push_word[atc_pkg::PAR_BIT-1:0] : ~^push_word[atc_pkg::PAR_BIT-1:0];
    end
  end

  // transmit fifo
  assign tx_full = tx_cnt_q == CW'(TX_DEPTH);
  assign push = (cpu_push || rep_push) && !tx_full;
  assign tx_go = mtick && st_q == atc_pkg::TX_IDLE && ten && tx_cnt_q != CW'(0);
  always_ff @(posedge ref_clk) begin
    if (push) tx_mem[tx_wp_q] <= push_word;
  end
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_wp_q <= '0;
      tx_rp_q <= '0;
      tx_cnt_q <= '0;
    end else if (mr) begin
      tx_wp_q <= '0;
      tx_rp_q <= '0;
      tx_cnt_q <= '0;
    end else begin
      if (push) tx_wp_q <= tx_wp_q + PW'(1);
      if (tx_go) tx_rp_q <= tx_rp_q + PW'(1);
      tx_cnt_q <= tx_cnt_q + CW'(push) - CW'(tx_go);
    end
  end
  assign tx_full_n = !tx_full;
  assign tx_half_n = tx_cnt_q < CW'(TX_DEPTH / 2);

  // line sequencer in master clock ticks
  assign half_ld = ctrl_q[atc_pkg::CB_RATE] ? atc_pkg::LS_HALF_LD : atc_pkg::HS_HALF_LD;
  assign gap_ld = ctrl_q[atc_pkg::CB_RATE] ? atc_pkg::LS_GAP_LD : atc_pkg::HS_GAP_LD;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= atc_pkg::TX_IDLE;
      tcnt_q <= 9'h000;
      bit_q <= 5'h00;
      sh_q <= 32'h0000_0000;
    end else if (mr) begin
      st_q <= atc_pkg::TX_IDLE;
      tcnt_q <= 9'h000;
      bit_q <= 5'h00;
    end else if (mtick) begin
      unique case (st_q)
        atc_pkg::TX_IDLE: begin
          if (tx_go) begin
            st_q <= atc_pkg::TX_DATA;
            sh_q <= tx_mem[tx_rp_q];
            tcnt_q <= half_ld;
            bit_q <= 5'h00;
          end
        end
        atc_pkg::TX_DATA: begin
          if (tcnt_q == 9'h000) begin
            st_q <= atc_pkg::TX_NULL;
            tcnt_q <= half_ld;
          end else begin
            tcnt_q <= tcnt_q - 9'h001;
          end
        end
        atc_pkg::TX_NULL: begin
          if (tcnt_q != 9'h000) begin
            tcnt_q <= tcnt_q - 9'h001;
          end else if (bit_q == 5'(atc_pkg::LAST_BIT)) begin
            st_q <= atc_pkg::TX_GAP;
            tcnt_q <= gap_ld;
          end else begin
            st_q <= atc_pkg::TX_DATA;
            bit_q <= bit_q + 5'h01;
            sh_q <= sh_q >> 1;
            tcnt_q <= half_ld;
          end
        end
        atc_pkg::TX_GAP: begin
          if (tcnt_q == 9'h000) begin
            st_q <= atc_pkg::TX_IDLE;
          end else begin
            tcnt_q <= tcnt_q - 9'h001;
          end
        end
      endcase
    end
  end

  // line and loopback levels; null is both low
  assign drv_a = st_q == atc_pkg::TX_DATA && sh_q[0];
  assign drv_b = st_q == atc_pkg::TX_DATA && !sh_q[0];
  assign loop_on = !ctrl_q[atc_pkg::CB_LOOP_N];
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      line_out_a <= 1'h0;
      line_out_b <= 1'h0;
      loop_rx1_a <= 1'h0;
      loop_rx1_b <= 1'h0;
      loop_rx2_a <= 1'h0;
      loop_rx2_b <= 1'h0;
    end else begin
      // test pin nulls the line outputs only; loopback outputs still follow the data
      line_out_a <= drv_a && !tst;
      line_out_b <= drv_b && !tst;
      loop_rx1_a <= loop_on && drv_a;
      loop_rx1_b <= loop_on && drv_b;
      loop_rx2_a <= loop_on && drv_b;
      loop_rx2_b <= loop_on && drv_a;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_ready <= 1'h1;
      word_complete_pulse <= 1'h0;
      line_slope_slow <= 1'h0;
    end else begin
      tx_ready <= tx_cnt_q == CW'(0) && st_q == atc_pkg::TX_IDLE;
      word_complete_pulse <= rx_if[0].accepted || rx_if[1].accepted;
      line_slope_slow <= ctrl_q[atc_pkg::CB_RATE];
    end
  end

  // read data
  assign status = {!tx_half_n, tx_full, tx_cnt_q == CW'(0),
                   rx_if[1].full, rx_if[1].half, rx_if[1].rdy,
                   rx_if[0].full, rx_if[0].half, rx_if[0].rdy};
  always_comb begin
    rdata_d = 32'h0000_0000;
    case (a_now)
      atc_pkg::A_CTRL: rdata_d[15:0] = ctrl_q;
      atc_pkg::A_STATUS: rdata_d[atc_pkg::SB_N-1:0] = status;
      atc_pkg::A_MODE: rdata_d[0] = repeat_q;
      default: rdata_d[15:0] = g_ch[0].rdat | g_ch[1].rdat;
    endcase
  end
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      hrdata <= 32'h0000_0000;
    end else if (rd) begin
      hrdata <= rdata_d;
    end
  end
endmodule

// ===== dv/atc_core_assertions.sv
// pin-level assertion checker for the terminal core
module atc_core_assertions (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // pins in
  input wire logic master_reset_n,
  input wire logic test_mode,
  // flags
  input wire logic rx1_ready_n,
  input wire logic rx1_half_n,
  input wire logic rx1_full_n,
  input wire logic rx2_ready_n,
  input wire logic rx2_half_n,
  input wire logic rx2_full_n,
  input wire logic tx_full_n,
  input wire logic tx_half_n,
  input wire logic tx_ready,
  input wire logic word_complete_pulse,
  // line and loopback
  input wire logic line_out_a,
  input wire logic line_out_b,
  input wire logic loop_rx1_a,
  input wire logic loop_rx1_b,
  input wire logic loop_rx2_a,
  input wire logic loop_rx2_b
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  AST_RX1_FULL: assert property (!rx1_full_n |-> !rx1_half_n && !rx1_ready_n)
    else $error("rx1 full flags");
  AST_RX2_FULL: assert property (!rx2_full_n |-> !rx2_half_n && !rx2_ready_n)
    else $error("rx2 full flags");
  AST_TX_FULL: assert property (!tx_full_n |-> !tx_half_n && !tx_ready)
    else $error("tx full flags");
  AST_TX_IDLE: assert property (tx_ready |-> tx_half_n && !line_out_a && !line_out_b)
    else $error("tx ready while busy");
  AST_LINE_CODE: assert property (!(line_out_a && line_out_b))
    else $error("both line outputs high");
  AST_BIT_HOLD: assert property ($rose(line_out_a) |-> line_out_a [*8])
    else $error("data half too short");
  AST_TEST_NULL: assert property (test_mode [*8] |-> !line_out_a && !line_out_b)
    else $error("test did not null line");
  AST_LOOP_INV: assert property (loop_rx2_a == loop_rx1_b && loop_rx2_b == loop_rx1_a)
    else $error("rx2 loopback not inverted");
  AST_EOS_RDY: assert property (word_complete_pulse |-> !(rx1_ready_n && rx2_ready_n))
    else $error("stray word pulse");
  AST_MR_CLEAR: assert property (!master_reset_n [*8] |->
    rx1_ready_n && rx2_ready_n && tx_full_n && tx_ready) else $error("master reset kept data");
  CV_RX_FULL: cover property (!rx1_full_n);
  CV_TX_FULL: cover property (!tx_full_n);
  CV_LINE: cover property ($rose(line_out_b));
endmodule

bind atc_core atc_core_assertions chk_u (.ref_clk, .rstn, .master_reset_n, .test_mode,
  .rx1_ready_n, .rx1_half_n, .rx1_full_n, .rx2_ready_n, .rx2_half_n, .rx2_full_n, .tx_full_n,
  .tx_half_n, .tx_ready, .line_out_a, .line_out_b, .loop_rx1_a, .loop_rx1_b, .loop_rx2_a,
  .loop_rx2_b, .word_complete_pulse);

// ===== dv/atc_rx_feed.sv
// far-side model: bit checkers handing finished words to the core
module atc_rx_feed (
  // clock
  clk,
  // words toward the core
  rx1_word_valid,
  rx1_word,
  rx2_word_valid,
  rx2_word
);
  timeunit 1ns;
  timeprecision 1ns;
  input wire logic clk;
  output logic rx1_word_valid = 1'b0;
  output logic [31:0] rx1_word = 32'h0;
  output logic rx2_word_valid = 1'b0;
  output logic [31:0] rx2_word = 32'h0;
  // stale word shows its inverse
  task automatic send(input logic ch, input logic [31:0] w);
    if (ch) begin
      rx2_word_valid <= 1'b1;
      rx2_word <= w;
    end else begin
      rx1_word_valid <= 1'b1;
      rx1_word <= w;
    end
    @(posedge clk);
    rx1_word_valid <= 1'b0;
    rx2_word_valid <= 1'b0;
    rx1_word <= ~w;
    rx2_word <= ~w;
    repeat (4) @(posedge clk);
  endtask
endmodule

// ===== dv/tb.sv
// self-checking bench for the terminal core
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [7:0] RX1_HI = atc_pkg::A_RX1_LO + atc_pkg::HALF_STEP;
  localparam logic [7:0] RX2_LO = atc_pkg::A_RX1_LO + atc_pkg::CH_STRIDE;
  logic ref_clk = 1'b0, rstn = 1'b0, hsel = 1'b0, hwrite = 1'b0, hreadyout, hresp;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rx1_word, rx2_word, w, c;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h0;
  logic master_reset_n = 1'b1, tx_enable = 1'b0, test_mode = 1'b0, rx1_word_valid;
  logic rx2_word_valid, rx1_ready_n, rx2_ready_n, rx1_half_n, rx2_half_n, rx1_full_n;
  logic rx2_full_n, tx_full_n, tx_half_n, tx_ready, line_out_a, line_out_b, line_slope_slow;
  logic loop_rx1_a, loop_rx1_b, loop_rx2_a, loop_rx2_b;
  logic [15:0] r;
  logic [15:0] cfg [3] = '{16'h8000, 16'h8010, 16'h9010};
  int bad_count = 0, check_count = 0, n;
  time tp = 0;
  always #50 ref_clk = ~ref_clk;
  atc_core dut_u (.ref_clk, .rstn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hreadyout, .hresp, .hrdata, .master_reset_n, .tx_enable, .test_mode,
    .rx1_word_valid, .rx1_word, .rx2_word_valid, .rx2_word, .rx1_ready_n, .rx2_ready_n,
    .rx1_half_n, .rx2_half_n, .rx1_full_n, .rx2_full_n, .tx_full_n, .tx_half_n, .tx_ready,
    .word_complete_pulse(), .line_out_a, .line_out_b, .line_slope_slow, .loop_rx1_a,
    .loop_rx1_b, .loop_rx2_a, .loop_rx2_b);
  atc_rx_feed p_u (.clk(ref_clk), .rx1_word_valid, .rx1_word, .rx2_word_valid, .rx2_word);
  task automatic end_sim();
    if (bad_count == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tick(inout int k);
    @(posedge ref_clk);
    k++;
    if (k > 5000) begin
      bad_count++;
      end_sim();
    end
  endtask
  // spare edge lets flags settle
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [15:0] d);
    int k;
    k = 0;
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    hsize <= atc_pkg::HSIZE_WORD;
    do tick(k); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= {16'h0, d};
    do tick(k); while (hreadyout !== 1'b1);
    r = hrdata[15:0];
    @(posedge ref_clk);
  endtask
  function automatic logic [31:0] wd(input int i);
    return 32'h2468_1357 ^ (32'(i) * 32'h0001_0203);
  endfunction
  initial begin
    repeat (20) @(posedge ref_clk);
    rstn <= 1'b1;
    repeat (3) @(posedge ref_clk);
    xfer(0, atc_pkg::A_CTRL, 0);
    chk(r, 16'h0020);
    xfer(1, atc_pkg::A_CTRL, 16'h8020);
    for (int i = 0; i < 33; i++) begin
      if (i == 15 || i == 16) chk(rx1_half_n, i == 15);
      if (i == 31 || i == 32) chk(rx1_full_n, i == 31);
      p_u.send(1'b0, wd(i));
    end
    for (int i = 0; i < 32; i++) begin
      w = wd(i == 31 ? 32 : i);
      xfer(0, atc_pkg::A_RX1_LO, 0);
      chk(r, w[15:0]);
      if (i == 31) chk(rx1_ready_n, 1'b0);
      xfer(0, RX1_HI, 0);
      chk(r, {~^w, w[30:16]});
    end
    chk(rx1_ready_n, 1'b1);
    xfer(1, atc_pkg::A_CTRL, 16'h8022);
    for (int i = 0; i < 16; i++) xfer(1, atc_pkg::A_TX_LO, 16'(i * 17));
    p_u.send(1'b0, 32'h0);
    chk(rx1_ready_n, 1'b1);
    for (int i = 0; i < 16; i++) begin
      xfer(0, RX1_HI, 0);
      chk(r, 16'(i * 17));
    end
    xfer(1, atc_pkg::A_CTRL, 16'h0004);
    p_u.send(1'b0, 32'h0000_00FE);
    chk(rx1_ready_n, 1'b1);
    p_u.send(1'b0, 32'h0000_0100);
    chk(rx1_ready_n, 1'b0);
    xfer(0, atc_pkg::A_RX1_LO, 0);
    chk(r, 16'h0800);
    xfer(0, RX1_HI, 0);
    xfer(1, atc_pkg::A_CTRL, 16'h0040);
    p_u.send(1'b0, 32'h0000_0100);
    chk(rx1_ready_n, 1'b1);
    for (int k = 0; k < 3; k++) begin
      w = 32'hA5C3_0F00 + 32'(k);
      xfer(1, atc_pkg::A_CTRL, cfg[k]);
      xfer(1, atc_pkg::A_TX_LO, w[15:0]);
      xfer(1, atc_pkg::A_TX_HI, w[31:16]);
    end
    chk(tx_ready, 1'b0);
    tx_enable <= 1'b1;
    for (int k = 0; k < 3; k++) begin
      for (int b = 0; b < 32; b++) begin
        n = 0;
        do tick(n); while (!(line_out_a | line_out_b));
        if (k == 0 && b == 0) chk(n <= 250, 1'b1);
        if (b == 1) chk(32'($time - tp), 32'd10000);
        if (k == 1 && b == 0) chk(32'($time - tp), 32'd50000);
        tp = $time;
        repeat (3) @(posedge ref_clk);
        c[b] = line_out_a;
        chk(loop_rx1_a, line_out_a);
        n = 0;
        do tick(n); while (line_out_a | line_out_b);
      end
      w = 32'hA5C3_0F00 + 32'(k);
      chk(c, k == 0 ? w : {^w[30:0] ^ (k == 1), w[30:0]});
    end
    n = 0;
    do tick(n); while (tx_ready !== 1'b1);
    chk(tx_ready, 1'b1);
    tx_enable <= 1'b0;
    xfer(1, atc_pkg::A_CTRL, 16'hA000);
    xfer(1, atc_pkg::A_MODE, 16'h0001);
    p_u.send(1'b1, wd(5));
    xfer(0, RX2_LO, 0);
    xfer(0, RX2_LO + atc_pkg::HALF_STEP, 0);
    chk(tx_ready, 1'b0);
    xfer(1, atc_pkg::A_MODE, 16'h0000);
    for (int i = 0; i < 32; i++) begin
      if (i == 14) chk(tx_half_n, 1'b1);
      xfer(1, atc_pkg::A_TX_LO, 16'(i));
      xfer(1, atc_pkg::A_TX_HI, 16'h0);
    end
    xfer(0, atc_pkg::A_STATUS, 0);
    chk(r, 16'h0180);
    p_u.send(1'b1, wd(6));
    master_reset_n <= 1'b0;
    repeat (8) @(posedge ref_clk);
    chk({rx2_ready_n, tx_full_n, tx_half_n, tx_ready}, 4'hF);
    master_reset_n <= 1'b1;
    repeat (4) @(posedge ref_clk);
    xfer(0, atc_pkg::A_CTRL, 0);
    chk(r, 16'hA000);
    chk(line_slope_slow, 1'b1);
    test_mode <= 1'b1;
    repeat (10) @(posedge ref_clk);
    test_mode <= 1'b0;
    end_sim();
  end
endmodule
